// ===== rtl/cts_cfg.svh
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH

// Register byte offsets on the Avalon-MM slave.
`define CTS_OFS_CTRL 6'h00
`define CTS_OFS_T0_PERIOD 6'h04
`define CTS_OFS_T0_WIDTH 6'h08
`define CTS_OFS_T1_PERIOD 6'h0C
`define CTS_OFS_T1_WIDTH 6'h10
`define CTS_OFS_TIME_LO 6'h14
`define CTS_OFS_TIME_HI 6'h18
`define CTS_OFS_STAMP_LO 6'h1C
`define CTS_OFS_STAMP_HI 6'h20
`define CTS_OFS_STATUS 6'h24

// Control register fields.
`define CTS_CTRL_TRIG0_EN 0
`define CTS_CTRL_TRIG1_EN 1
`define CTS_CTRL_PPS_EN 2
`define CTS_CTRL_SRC 3
`define CTS_CTRL_RESET 32'h0000_0000

// Status register fields.
`define CTS_STAT_PENDING 0
`define CTS_STAT_TRIG0 1
`define CTS_STAT_TRIG1 2
`define CTS_STAT_SYNC_SEEN 3

// Trigger setting reset values, in microseconds.
`define CTS_PERIOD_RESET 32'h0000_0000
`define CTS_WIDTH_RESET 32'h0000_0000

// Timebase: one timestamp step is one microsecond.
`define CTS_CLK_PERIOD_NS 25
`define CTS_STEP_NS 1000
`define CTS_STEP_CYCLES (`CTS_STEP_NS / `CTS_CLK_PERIOD_NS)

// Power-up epoch: seconds from 1970 to the start of 2017, times one million.
`define CTS_EPOCH_SEC 64'h0000_0000_5868_4680
`define CTS_US_PER_SEC 64'h0000_0000_000F_4240
`define CTS_EPOCH_US (`CTS_EPOCH_SEC * `CTS_US_PER_SEC)

`endif

// ===== rtl/cts_pkg.sv
package cts_pkg;
  typedef logic signed [63:0] cts_time_t;
  typedef enum logic {CTS_SRC_TRIGGER, CTS_SRC_ARRIVAL} cts_src_e;
  typedef enum logic [0:0] {CTS_IDLE, CTS_PENDING} cts_frame_e;
endpackage

// ===== rtl/cts_time_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cts_time_if;
  import cts_pkg::*;
  logic us_tick;
  logic sync_evt;
  cts_time_t time_now;
  modport src (output us_tick, output sync_evt, output time_now);
  modport sink (input us_tick, input sync_evt, input time_now);
endinterface
`default_nettype wire

// ===== rtl/cts_trig_gen.sv
`timescale 1ns/100ps
`default_nettype none
module cts_trig_gen
  import cts_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_sync_n,
  input wire logic enable,
  input wire logic [31:0] period_us,
  input wire logic [31:0] width_us,
  cts_time_if.sink tb,
  output logic trig,
  output logic fire
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_trig;
  logic next_fire;
  logic run;

  // A zero period parks the channel low rather than pulsing every step.
  assign run = enable && (period_us != 32'h0000_0000);

  always_comb begin
    next_cnt = cnt;
    next_trig = trig;
    next_fire = 1'b0;
    if (!run) begin
      next_cnt = 32'h0000_0000;
      next_trig = 1'b0;
    end else if (tb.us_tick) begin
      next_cnt = (cnt >= period_us - 32'h0000_0001) ? 32'h0000_0000 : cnt + 32'h0000_0001;
      next_trig = (cnt < width_us); // RULE2 RULE3
      next_fire = (cnt == 32'h0000_0000) && (width_us != 32'h0000_0000);
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt <= 32'h0000_0000;
      trig <= 1'b0;
      fire <= 1'b0;
    end else begin
      cnt <= next_cnt;
      trig <= next_trig;
      fire <= next_fire;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/cts_stamp_clk.sv
`timescale 1ns/100ps
`default_nettype none
`include "cts_cfg.svh"
module cts_stamp_clk
  import cts_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_sync_n,
  input wire logic pps_en,
  input wire logic pps_in,
  cts_time_if.src tb
);
  localparam logic [5:0] STEP_LAST = 6'(`CTS_STEP_CYCLES - 1);
  logic pps_meta;
  logic pps_sync;
  logic pps_prev;
  logic [5:0] pre;
  logic [5:0] next_pre;
  cts_time_t next_time;
  logic next_tick;
  logic next_sync;
  logic rise;

  assign rise = pps_sync && !pps_prev;

  always_comb begin
    next_pre = (pre == STEP_LAST) ? 6'h00 : pre + 6'h01;
    next_tick = (pre == STEP_LAST);
    next_sync = rise && pps_en; // RULE12
    next_time = tb.time_now;
    if (tb.us_tick) begin
      next_time = tb.time_now + 64'sh0000_0000_0000_0001; // RULE8
    end
    if (tb.sync_evt) begin
      // Restarting the prescaler makes the first step after a sync a full microsecond.
      next_time = 64'sh0000_0000_0000_0000; // RULE5
      next_pre = 6'h00;
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pps_meta <= 1'b0;
      pps_sync <= 1'b0;
      pps_prev <= 1'b0;
      pre <= 6'h00;
      tb.us_tick <= 1'b0;
      tb.sync_evt <= 1'b0;
      tb.time_now <= cts_time_t'(`CTS_EPOCH_US); // RULE10
    end else begin
      pps_meta <= pps_in; // RULE12
      pps_sync <= pps_meta;
      pps_prev <= pps_sync;
      pre <= next_pre;
      tb.us_tick <= next_tick;
      tb.sync_evt <= next_sync;
      tb.time_now <= next_time;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/cts_top.sv
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cts_cfg.svh"
// What this block does, and what it expects of the cameras and the sync source
// RULE1: Two independent trigger outputs, usable together.
// RULE2: Triggers are active high, resting low.
// RULE3: Pulse width and period come from registers.
// RULE4: Cameras should expose on the rising edge.
// RULE5: Enabled sync edge clears the timestamp clock.
// RULE6: Sync source gives one rising edge per second.
// RULE7: Every result carries its latched timestamp; the code drops a latch made while a frame is pending, except one in the same cycle as result_done.
// RULE8: Timestamp clock counts whole microseconds.
// RULE9: Setting picks trigger or arrival as latch point.
// RULE10: Unsynced clock starts at the 2017 epoch.
// RULE11: Sync during a frame yields negative stamp.
// RULE12: Sync input synchronised, edge-detected, gated by enable.
module cts_top
  import cts_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pps_in,
  input wire logic frame_arrive,
  input wire logic result_done,
  output logic [1:0] trig_out,
  output cts_time_t result_stamp,
  output logic result_stamp_valid
);
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  function automatic logic [31:0] merge_be(input logic [31:0] old_val, input logic [31:0] wdata,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  cts_time_if tb ();

  logic [31:0] ctrl;
  logic [31:0] period [2];
  logic [31:0] width [2];
  logic [1:0] fire;
  logic [1:0] trig;

  cts_stamp_clk u_stamp (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n),
    .pps_en(ctrl[`CTS_CTRL_PPS_EN]),
    .pps_in(pps_in),
    .tb(tb.src)
  );

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_trig
      cts_trig_gen u_trig (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .enable(ctrl[`CTS_CTRL_TRIG0_EN + ch]), // RULE1
        .period_us(period[ch]),
        .width_us(width[ch]),
        .tb(tb.sink),
        .trig(trig[ch]),
        .fire(fire[ch])
      );
    end
  endgenerate

  // The generator outputs are already flops, so the pins take them directly.
  assign trig_out = trig; // RULE1 RULE2

  // Frame time tracking.
  cts_frame_e state;
  cts_frame_e next_state;
  cts_time_t ref_time;
  cts_time_t next_ref_time;
  cts_time_t next_result_stamp;
  logic next_result_valid;
  logic latch_evt;
  cts_time_t now_stamp;
  cts_src_e src;

  assign src = cts_src_e'(ctrl[`CTS_CTRL_SRC]);
  // The rising edge of a trigger is the exposure start the cameras should use.
  assign latch_evt = (src == CTS_SRC_TRIGGER) ? (|fire) : frame_arrive; // RULE9 RULE4
  // A latch that coincides with a sync lands exactly at time zero.
  assign now_stamp = tb.sync_evt ? 64'sh0000_0000_0000_0000 : tb.time_now;

  always_comb begin
    next_state = state;
    next_ref_time = ref_time;
    next_result_stamp = result_stamp;
    next_result_valid = 1'b0;
    unique case (state)
      CTS_IDLE: begin
        if (latch_evt) begin
          next_ref_time = now_stamp;
          next_state = CTS_PENDING;
        end
      end
      CTS_PENDING: begin
        if (tb.sync_evt) begin
          // Rebase the reference on the new zero; it goes negative.
          next_ref_time = ref_time - tb.time_now; // RULE11
        end
        if (result_done) begin
          next_result_stamp = next_ref_time; // RULE7
          next_result_valid = 1'b1;
          if (latch_evt) begin
            next_ref_time = now_stamp;
          end else begin
            next_state = CTS_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= CTS_IDLE;
      ref_time <= 64'sh0000_0000_0000_0000;
      result_stamp <= 64'sh0000_0000_0000_0000;
      result_stamp_valid <= 1'b0;
    end else begin
      state <= next_state;
      ref_time <= next_ref_time;
      result_stamp <= next_result_stamp;
      result_stamp_valid <= next_result_valid;
    end
  end

  // Register map, as byte offsets of 32-bit words.
  // Offset 0x00 is control: bits 0 and 1 enable the two trigger channels, bit 2 enables the sync input.
  // Control bit 3 picks the latch point: 0 for a trigger start, 1 for a frame arrival.
  // Offsets 0x04 and 0x08 hold period and high time of channel 0, 0x0C and 0x10 those of channel 1.
  // Trigger settings count whole microseconds; a zero period parks the channel low.
  // Offsets 0x14 and 0x18 read the timestamp clock; the low word freezes the high word for the next read.
  // Offsets 0x1C and 0x20 read the stamp of the last result and ignore writes.
  // Offset 0x24 is status: pending frame, both trigger levels and a sync flag that a written 1 clears.
  // Unmapped reads return zero and unmapped writes are dropped, so software probing is harmless.
  // Avalon-MM slave: every access is answered one cycle after it is seen.
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic [31:0] next_ctrl;
  logic [31:0] next_period [2];
  logic [31:0] next_width [2];
  logic [31:0] time_hi_snap;
  logic [31:0] next_time_hi_snap;
  logic sync_seen;
  logic next_sync_seen;
  logic wr_go;
  logic rd_go;
  logic [31:0] status;

  // Writes take effect at the edge where waitrequest is sampled low; reads are taken one edge earlier, while it is still high.
  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && avs_waitrequest;
  assign status = {28'h000_0000, sync_seen, trig, state == CTS_PENDING};

  always_comb begin
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
    next_readdata = avs_readdata;
    next_ctrl = ctrl;
    next_period = period;
    next_width = width;
    next_time_hi_snap = time_hi_snap;
    // A sync arriving with the clearing write still sets the flag.
    next_sync_seen = sync_seen;
    if (wr_go) begin
      unique case (avs_address)
        `CTS_OFS_CTRL: next_ctrl = merge_be(ctrl, avs_writedata, avs_byteenable) & 32'h0000_000F;
        `CTS_OFS_T0_PERIOD: next_period[0] = merge_be(period[0], avs_writedata, avs_byteenable); // RULE3
        `CTS_OFS_T0_WIDTH: next_width[0] = merge_be(width[0], avs_writedata, avs_byteenable);
        `CTS_OFS_T1_PERIOD: next_period[1] = merge_be(period[1], avs_writedata, avs_byteenable);
        `CTS_OFS_T1_WIDTH: next_width[1] = merge_be(width[1], avs_writedata, avs_byteenable);
        `CTS_OFS_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[`CTS_STAT_SYNC_SEEN]) begin
            next_sync_seen = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (tb.sync_evt) begin
      next_sync_seen = 1'b1;
    end
    if (rd_go) begin
      unique case (avs_address)
        `CTS_OFS_CTRL: next_readdata = ctrl;
        `CTS_OFS_T0_PERIOD: next_readdata = period[0];
        `CTS_OFS_T0_WIDTH: next_readdata = width[0];
        `CTS_OFS_T1_PERIOD: next_readdata = period[1];
        `CTS_OFS_T1_WIDTH: next_readdata = width[1];
        `CTS_OFS_TIME_LO: begin
          // Snapshot the upper half so a low-then-high read pair is coherent.
          next_readdata = tb.time_now[31:0];
          next_time_hi_snap = tb.time_now[63:32];
        end
        `CTS_OFS_TIME_HI: next_readdata = time_hi_snap;
        `CTS_OFS_STAMP_LO: next_readdata = result_stamp[31:0];
        `CTS_OFS_STAMP_HI: next_readdata = result_stamp[63:32];
        `CTS_OFS_STATUS: next_readdata = status;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl <= `CTS_CTRL_RESET;
      period[0] <= `CTS_PERIOD_RESET;
      period[1] <= `CTS_PERIOD_RESET;
      width[0] <= `CTS_WIDTH_RESET;
      width[1] <= `CTS_WIDTH_RESET;
      time_hi_snap <= 32'h0000_0000;
      sync_seen <= 1'b0;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      ctrl <= next_ctrl;
      period <= next_period;
      width <= next_width;
      time_hi_snap <= next_time_hi_snap;
      sync_seen <= next_sync_seen;
    end
  end
endmodule
`default_nettype wire

// ===== test/cts_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module cts_top_props
  import cts_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic result_done,
  input wire logic [1:0] trig_out,
  input wire cts_time_t result_stamp,
  input wire logic result_stamp_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("access not answered");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
  property p_rdata_hold;
    $changed(avs_readdata) |-> !avs_waitrequest && avs_read;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_valid_cause;
    result_stamp_valid |-> $past(result_done);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("stray stamp");
  property p_valid_pulse;
    result_stamp_valid |=> !result_stamp_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
  property p_stamp_hold;
    !result_stamp_valid |-> $stable(result_stamp);
  endproperty
  a_stamp_hold: assert property (p_stamp_hold) else $error("stamp moved");
  property p_trig_high;
    $rose(trig_out[0]) |-> trig_out[0] [*8];
  endproperty
  a_trig_high: assert property (p_trig_high) else $error("pulse too short");
  property p_trig_low;
    $fell(trig_out[1]) |-> !trig_out[1] [*8];
  endproperty
  a_trig_low: assert property (p_trig_low) else $error("gap too short");
endmodule
bind cts_top cts_top_props cts_top_props_i (.core_clk(core_clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .result_done(result_done), .trig_out(trig_out),
  .result_stamp(result_stamp), .result_stamp_valid(result_stamp_valid));
`default_nettype wire

// ===== test/cts_cam_model.sv
`timescale 1ns/100ps
`default_nettype none
module cts_cam_model #(
  parameter int DELAY = 7
) (
  input wire logic core_clk,
  input wire logic [1:0] trig_out,
  input wire logic pps_kick,
  output logic frame_arrive,
  output logic pps_in
);
  logic t_q = 1'b0;
  int cnt = 0;
  int pcnt = 0;
  initial frame_arrive = 1'b0;
  initial pps_in = 1'b0;
  // The camera exposes on the rising edge and delivers its frame a fixed time later.
  always @(posedge core_clk) begin
    t_q <= trig_out[0];
    frame_arrive <= (cnt == 1);
    if (trig_out[0] && !t_q) cnt <= DELAY;
    else if (cnt > 0) cnt <= cnt - 1;
    if (pps_kick) pcnt <= 8;
    else if (pcnt > 0) pcnt <= pcnt - 1;
    pps_in <= pps_kick || (pcnt > 1);
  end
endmodule
`default_nettype wire

// ===== test/tb_cts_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cts_top
  import cts_pkg::*;
;
  localparam logic [63:0] EPOCH_US = 64'h0000_0000_5868_4680 * 64'h0000_0000_000F_4240;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pps_in;
  logic cam_frame;
  logic [2:0] ev = 3'h0;
  logic [1:0] trig_out;
  cts_time_t result_stamp;
  logic result_stamp_valid;
  cts_time_t exp_q[$];
  logic [5:0] ra [7] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h24, 6'h3C};
  int fails = 0;
  int samples_checked = 0;
  int seed = 54;
  int hi, per, w, p;
  always #12.5 core_clk = ~core_clk;
  cts_top cts_top_i (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pps_in(pps_in), .frame_arrive(cam_frame | ev[0]), .result_done(ev[1]),
    .trig_out(trig_out), .result_stamp(result_stamp), .result_stamp_valid(result_stamp_valid));
  cts_cam_model cts_cam_model_i (.core_clk(core_clk), .trig_out(trig_out), .pps_kick(ev[2]),
    .frame_arrive(cam_frame), .pps_in(pps_in));
  task automatic final_report;
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 3'h0;
  endtask
  // The request stands until the rising edge that samples waitrequest low; data is taken at that edge.
  task automatic bus(input logic wr_en, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr_en;
    avs_read <= !wr_en;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      fails++;
      final_report;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // The low word snapshots the high word, so the pair is read in that order.
  task automatic rdhi(input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, 6'h14, 32'h0, q);
    rdchk(6'h18, e);
  endtask
  task automatic meas(input int ch, output int h, output int t);
    int n;
    n = 0;
    h = 0;
    while (trig_out[ch] !== 1'b0 && n < 2000) begin @(negedge core_clk); n++; end
    while (trig_out[ch] !== 1'b1 && n < 2000) begin @(negedge core_clk); n++; end
    while (trig_out[ch] === 1'b1 && n < 2000) begin @(negedge core_clk); n++; h++; end
    t = h;
    while (trig_out[ch] === 1'b0 && n < 2000) begin @(negedge core_clk); n++; t++; end
    if (n >= 2000) begin
      fails++;
      final_report;
    end
  endtask
  always @(negedge core_clk) begin
    if (rst_n && result_stamp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(64'h1, 64'h0);
      else chk(result_stamp, exp_q.pop_front());
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(5);
    for (int i = 0; i < 7; i++) rdchk(ra[i], 32'h0);
    wr(6'h1C, 32'hFFFF_FFFF);
    rdchk(6'h1C, 32'h0);
    pulse(3'h4);
    cyc(20);
    rdhi(EPOCH_US[63:32]);
    rdhi(EPOCH_US[63:32]);
    wr(6'h00, 32'h0000_000C);
    pulse(3'h4);
    cyc(10);
    pulse(3'h1);
    cyc(3);
    exp_q.push_back(64'h0);
    pulse(3'h2);
    pulse(3'h1);
    cyc(118);
    // The second edge lands three whole microseconds after the first one.
    pulse(3'h4);
    cyc(10);
    exp_q.push_back(-64'sh3);
    pulse(3'h2);
    cyc(3);
    rdhi(32'h0);
    wr(6'h00, 32'h0000_0004);
    pulse(3'h1);
    cyc(3);
    pulse(3'h2);
    cyc(3);
    w = 1 + $unsigned($random(seed)) % 3;
    p = w + 1 + $unsigned($random(seed)) % 3;
    wr(6'h04, p);
    wr(6'h08, w);
    wr(6'h0C, p);
    wr(6'h10, 32'h1);
    wr(6'h00, 32'h0000_0003);
    meas(0, hi, per);
    chk(hi, w * 40);
    chk(per, p * 40);
    meas(1, hi, per);
    chk(hi, 40);
    chk(per, p * 40);
    // Both channels just started a period; disable only once both pulses have ended.
    cyc(w * 40 + 5);
    wr(6'h00, 32'h0);
    cyc(45);
    chk(trig_out, 2'h0);
    chk(exp_q.size(), 64'h0);
    rdchk(6'h24, 32'h0000_0009);
    wr(6'h24, 32'h0000_0008);
    rdchk(6'h24, 32'h0000_0001);
    final_report;
  end
endmodule
`default_nettype wire
